// File: shared/rtcw_map.svh
// register offsets, field positions, reset values and timing counts
// assumes a 3-bit word address on the plain register port
`ifndef RTCW_MAP_SVH
`define RTCW_MAP_SVH

// ----------------------------------------
// register offsets (word index)
// ----------------------------------------
`define RTCW_OFS_TIME_TIME_MINUTES_SECONDS 3'h0
`define RTCW_OFS_ALARM_WINDOW 3'h1
`define RTCW_OFS_ALARM_CFG 3'h2
`define RTCW_OFS_POWER_CTRL 3'h3
`define RTCW_OFS_CLOCK_CFG 3'h4
`define RTCW_OFS_STATUS 3'h5

// ----------------------------------------
// alarm window pointer values
// ----------------------------------------
`define RTCW_PTR_TIME_MINUTES_SECONDS 2'h0
`define RTCW_PTR_WEEKDAY_DIGIT_HOUR 2'h1
`define RTCW_PTR_MONTH_DAY 2'h2
`define RTCW_PTR_WINDOWS 2'h3

// ----------------------------------------
// field positions and implemented-bit masks
// ----------------------------------------
`define RTCW_MASK_TIME_MINUTES_SECONDS 16'h7f7f
`define RTCW_MASK_MONTH_DAY 16'h1f3f
`define RTCW_MASK_WEEKDAY_DIGIT_HOUR 16'h073f
`define RTCW_MASK_WINDOWS 16'hffff
`define RTCW_BIT_PTR_LO 8
`define RTCW_BIT_PWC_EN 15
`define RTCW_BIT_PWC_POL 14
`define RTCW_BIT_STAB_PRE 13
`define RTCW_BIT_SAMP_PRE 12
`define RTCW_BIT_WR_EN 13
`define RTCW_STAB_HI 15
`define RTCW_STAB_LO 8
`define RTCW_SAMP_HI 7
`define RTCW_SAMP_LO 0

// ----------------------------------------
// reset values and timing counts
// ----------------------------------------
`define RTCW_RST_WORD 16'h0000
`define RTCW_SAMP_FOREVER 8'hff
`define RTCW_SRC_PER_SECOND 32768
`define RTCW_SEC_TOP 16'sh7fff

`endif

// File: shared/rtcw_pkg.sv
// types shared by the power window timer block
// assumes rtcw_map.svh supplies all numeric constants
package rtcw_pkg;

    typedef enum logic [1:0]
    {
        PWC_IDLE,
        PWC_STAB,
        PWC_SAMP
    } rtcw_pwc_state_type;

    typedef logic [15:0] rtcw_word_type;

endpackage

// File: core/rtcw_alarm_mem.sv
// four-word store for the alarm value window
// assumes writes arrive already masked; read data are registered
`timescale 1ns/10ps
module rtcw_alarm_mem
(
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [1:0] waddr_i,
    input wire rtcw_pkg::rtcw_word_type wdata_i,
    input wire logic [1:0] raddr_i,
    output rtcw_pkg::rtcw_word_type rdata_o
);
    import rtcw_pkg::*;

    rtcw_word_type mem_q [0:3];
    rtcw_word_type rdata_q;

    always_ff @(posedge clk_i)
    begin
        if (we_i)
        begin
            mem_q[waddr_i] <= wdata_i;
        end
    end

    // write-through keeps the read word current in the cycle after a write
    always_ff @(posedge clk_i)
    begin
        if (we_i && (waddr_i == raddr_i))
        begin
            rdata_q <= wdata_i;
        end
        else
        begin
            rdata_q <= mem_q[raddr_i];
        end
    end

    assign rdata_o = rdata_q;

endmodule

// File: core/rtcw_core.sv
// minutes/seconds time keeping, alarm value window, power window timers
// and per-minute calibration of the source clock prescaler.
// assumes SRC_TICK_I is a one-cycle enable at the source clock rate and
// ALARM_EVT_I a one-cycle pulse, both from logic on MCLK_I.
//
// Operation
// - minutes kept as packed BCD digits
// - seconds kept as packed BCD digits
// - unimplemented bits ignore writes, read zero
// - alarm month and day field layout
// - alarm weekday three bits, 0 to 6
// - alarm hour packed BCD, tens 0-2
// - gated alarm writes need write enable set
// - alarm time_minutes_seconds layout matches time time_minutes_seconds
// - stability window lasts count clock periods
// - zero stability starts sample at alarm
// - sample window lasts count clock periods
// - all-ones sample window stays always active
// - zero sample count gives no window
// - sample window starts when stability expires
// - signed calibration times four each minute
// - stability clock divided by two optionally
// - sample clock divided by two optionally
// - window pointer selects, decrements to zero
`timescale 1ns/10ps
`include "rtcw_map.svh"
module rtcw_core
(
    input wire logic MCLK_I,
    input wire logic NRST_I,
    input wire logic [2:0] ADDR_I,
    input wire rtcw_pkg::rtcw_word_type WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output rtcw_pkg::rtcw_word_type RDATA_O,
    input wire logic SRC_TICK_I,
    input wire logic ALARM_EVT_I,
    output logic SECOND_TICK_O,
    output logic MINUTE_TICK_O,
    output logic SAMPLE_WIN_O,
    output logic PWC_O
);
    import rtcw_pkg::*;

    // ----------------------------------------
    // functions
    // ----------------------------------------
    // increments a {tens[2:0], ones[3:0]} pair that wraps at 59
    function automatic logic [6:0] bcd59_inc(input logic [6:0] v);
        logic [6:0] r;
        r = v;
        if (v[3:0] == 4'h9)
        begin
            r[3:0] = 4'h0;
            r[6:4] = (v[6:4] == 3'h5) ? 3'h0 : v[6:4] + 3'h1;
        end
        else
        begin
            r[3:0] = v[3:0] + 4'h1;
        end
        return r;
    endfunction

    function automatic logic [15:0] word_mask(input logic [1:0] ptr);
        logic [15:0] m;
        m = `RTCW_MASK_TIME_MINUTES_SECONDS;
        case (ptr)
            `RTCW_PTR_TIME_MINUTES_SECONDS: m = `RTCW_MASK_TIME_MINUTES_SECONDS;
            `RTCW_PTR_WEEKDAY_DIGIT_HOUR: m = `RTCW_MASK_WEEKDAY_DIGIT_HOUR;
            `RTCW_PTR_MONTH_DAY: m = `RTCW_MASK_MONTH_DAY;
            default: m = `RTCW_MASK_WINDOWS;
        endcase
        return m;
    endfunction

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    logic wr_time, wr_win, rd_win, wr_cfg, wr_pwr, wr_clk;
    logic win_gated, win_we;
    logic [1:0] ptr_q, ptr_d;
    logic pwc_en_q, pwc_pol_q, stab_pre_q, samp_pre_q;
    logic wr_en_q;
    logic [7:0] cal_q;
    logic [15:0] time_minutes_seconds_q;
    logic [15:0] windows_q;
    rtcw_word_type mem_rdata;
    rtcw_pwc_state_type state_q;
    logic [7:0] cnt_q;
    logic div_q;
    logic stab_tick, samp_tick;
    logic sec_wrap, min_wrap;
    logic signed [15:0] pre_q;
    logic active, samp_active;

    assign wr_time = WR_I && (ADDR_I == `RTCW_OFS_TIME_TIME_MINUTES_SECONDS);
    assign wr_win = WR_I && (ADDR_I == `RTCW_OFS_ALARM_WINDOW);
    assign rd_win = RD_I && (ADDR_I == `RTCW_OFS_ALARM_WINDOW);
    assign wr_cfg = WR_I && (ADDR_I == `RTCW_OFS_ALARM_CFG);
    assign wr_pwr = WR_I && (ADDR_I == `RTCW_OFS_POWER_CTRL);
    assign wr_clk = WR_I && (ADDR_I == `RTCW_OFS_CLOCK_CFG);

    // only the alarm minutes/seconds word is open without write enable
    assign win_gated = (ptr_q != `RTCW_PTR_TIME_MINUTES_SECONDS);
    assign win_we = wr_win && (!win_gated || wr_en_q);

    // ----------------------------------------
    // alarm window pointer
    // ----------------------------------------
    always_comb
    begin
        ptr_d = ptr_q;
        if (wr_cfg)
        begin
            ptr_d = WDATA_I[`RTCW_BIT_PTR_LO +: 2];
        end
        else if ((wr_win || rd_win) && (ptr_q != `RTCW_PTR_TIME_MINUTES_SECONDS))
        begin
            ptr_d = ptr_q - 2'h1;
        end
    end

    always_ff @(posedge MCLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            ptr_q <= 2'h0;
        end
        else
        begin
            ptr_q <= ptr_d;
        end
    end

    // read port tracks the next pointer so a read sees the current word
    rtcw_alarm_mem u_alarm_mem
    (
        .clk_i(MCLK_I),
        .we_i(win_we),
        .waddr_i(ptr_q),
        .wdata_i(WDATA_I & word_mask(ptr_q)),
        .raddr_i(ptr_d),
        .rdata_o(mem_rdata)
    );

    // shadow of the window timer word, feeds the power control sequencer
    always_ff @(posedge MCLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            windows_q <= `RTCW_RST_WORD;
        end
        else if (win_we && (ptr_q == `RTCW_PTR_WINDOWS))
        begin
            windows_q <= WDATA_I;
        end
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    always_ff @(posedge MCLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            pwc_en_q <= 1'b0;
            pwc_pol_q <= 1'b0;
            stab_pre_q <= 1'b0;
            samp_pre_q <= 1'b0;
        end
        else if (wr_pwr)
        begin
            pwc_en_q <= WDATA_I[`RTCW_BIT_PWC_EN];
            pwc_pol_q <= WDATA_I[`RTCW_BIT_PWC_POL];
            stab_pre_q <= WDATA_I[`RTCW_BIT_STAB_PRE];
            samp_pre_q <= WDATA_I[`RTCW_BIT_SAMP_PRE];
        end
    end

    always_ff @(posedge MCLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            wr_en_q <= 1'b0;
            cal_q <= 8'h00;
        end
        else if (wr_clk)
        begin
            wr_en_q <= WDATA_I[`RTCW_BIT_WR_EN];
            cal_q <= WDATA_I[7:0];
        end
    end

    // ----------------------------------------
    // time keeping and calibration
    // ----------------------------------------
    assign sec_wrap = SRC_TICK_I && (pre_q == `RTCW_SEC_TOP);
    assign min_wrap = sec_wrap && (time_minutes_seconds_q[6:0] == 7'h59);

    // a minute wrap restarts the prescaler at cal*4: positive shortens
    // the next second, negative lengthens it
    always_ff @(posedge MCLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            pre_q <= 16'sh0000;
        end
        else if (wr_time)
        begin
            pre_q <= 16'sh0000;
        end
        else if (min_wrap)
        begin
            pre_q <= {{6{cal_q[7]}}, cal_q, 2'b00};
        end
        else if (sec_wrap)
        begin
            pre_q <= 16'sh0000;
        end
        else if (SRC_TICK_I)
        begin
            pre_q <= pre_q + 16'sh0001;
        end
    end

    always_ff @(posedge MCLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            time_minutes_seconds_q <= `RTCW_RST_WORD;
        end
        else if (wr_time)
        begin
            time_minutes_seconds_q <= WDATA_I & `RTCW_MASK_TIME_MINUTES_SECONDS;
        end
        else if (sec_wrap)
        begin
            time_minutes_seconds_q[6:0] <= bcd59_inc(time_minutes_seconds_q[6:0]);
            if (min_wrap)
            begin
                time_minutes_seconds_q[14:8] <= bcd59_inc(time_minutes_seconds_q[14:8]);
            end
        end
    end

    // ----------------------------------------
    // power window clock enables
    // ----------------------------------------
    always_ff @(posedge MCLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            div_q <= 1'b0;
        end
        else if (SRC_TICK_I)
        begin
            div_q <= ~div_q;
        end
    end

    assign stab_tick = SRC_TICK_I && (!stab_pre_q || div_q);
    assign samp_tick = SRC_TICK_I && (!samp_pre_q || div_q);

    // ----------------------------------------
    // power control sequencer
    // ----------------------------------------
    always_ff @(posedge MCLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            state_q <= PWC_IDLE;
            cnt_q <= 8'h00;
        end
        else if (!pwc_en_q)
        begin
            state_q <= PWC_IDLE;
            cnt_q <= 8'h00;
        end
        else
        begin
            case (state_q)
                PWC_IDLE:
                begin
                    if (ALARM_EVT_I)
                    begin
                        if (windows_q[`RTCW_STAB_HI:`RTCW_STAB_LO] != 8'h00)
                        begin
                            state_q <= PWC_STAB;
                            cnt_q <= windows_q[`RTCW_STAB_HI:`RTCW_STAB_LO];
                        end
                        else if (windows_q[`RTCW_SAMP_HI:`RTCW_SAMP_LO] != 8'h00)
                        begin
                            state_q <= PWC_SAMP;
                            cnt_q <= windows_q[`RTCW_SAMP_HI:`RTCW_SAMP_LO];
                        end
                    end
                end
                PWC_STAB:
                begin
                    if (stab_tick)
                    begin
                        if (cnt_q == 8'h01)
                        begin
                            cnt_q <= windows_q[`RTCW_SAMP_HI:`RTCW_SAMP_LO];
                            if (windows_q[`RTCW_SAMP_HI:`RTCW_SAMP_LO] == 8'h00)
                            begin
                                state_q <= PWC_IDLE;
                            end
                            else
                            begin
                                state_q <= PWC_SAMP;
                            end
                        end
                        else
                        begin
                            cnt_q <= cnt_q - 8'h01;
                        end
                    end
                end
                PWC_SAMP:
                begin
                    // the all-ones setting never counts down
                    if (samp_tick && (windows_q[`RTCW_SAMP_HI:`RTCW_SAMP_LO]
                        != `RTCW_SAMP_FOREVER))
                    begin
                        if (cnt_q == 8'h01)
                        begin
                            state_q <= PWC_IDLE;
                        end
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                default:
                begin
                    state_q <= PWC_IDLE;
                end
            endcase
        end
    end

    assign active = (state_q != PWC_IDLE);
    assign samp_active = (state_q == PWC_SAMP) ||
        (windows_q[`RTCW_SAMP_HI:`RTCW_SAMP_LO] == `RTCW_SAMP_FOREVER);

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    always_ff @(posedge MCLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            PWC_O <= 1'b1;
            SAMPLE_WIN_O <= 1'b0;
            SECOND_TICK_O <= 1'b0;
            MINUTE_TICK_O <= 1'b0;
        end
        else
        begin
            PWC_O <= pwc_pol_q ? active : ~active;
            SAMPLE_WIN_O <= samp_active;
            SECOND_TICK_O <= sec_wrap;
            MINUTE_TICK_O <= min_wrap;
        end
    end

    // ----------------------------------------
    // read data, one cycle after the strobe
    // ----------------------------------------
    always_ff @(posedge MCLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            RDATA_O <= 16'h0000;
        end
        else if (RD_I)
        begin
            case (ADDR_I)
                `RTCW_OFS_TIME_TIME_MINUTES_SECONDS: RDATA_O <= time_minutes_seconds_q;
                `RTCW_OFS_ALARM_WINDOW: RDATA_O <= mem_rdata;
                `RTCW_OFS_ALARM_CFG: RDATA_O <= {6'h00, ptr_q, 8'h00};
                `RTCW_OFS_POWER_CTRL: RDATA_O <= {pwc_en_q, pwc_pol_q,
                    stab_pre_q, samp_pre_q, 12'h000};
                `RTCW_OFS_CLOCK_CFG: RDATA_O <= {2'h0, wr_en_q, 5'h00, cal_q};
                `RTCW_OFS_STATUS: RDATA_O <= {13'h0000, samp_active,
                    (state_q == PWC_STAB), active};
                default: RDATA_O <= 16'h0000;
            endcase
        end
        else
        begin
            RDATA_O <= 16'h0000;
        end
    end

endmodule

// File: dv/rtcw_load_switch.sv
// external load switch fed from the power control line
// assumes the bench mirrors the polarity bit it wrote
`timescale 1ns/10ps
module rtcw_load_switch
(
    input wire logic pwc_i,
    input wire logic pol_i,
    output logic powered_o
);
    // an unknown line never counts as powered
    assign powered_o = (pwc_i === pol_i);
endmodule

// File: dv/rtcw_core_asserts.sv
// port-level checks for the power window timer block
// assumes one clock domain and the registered read port
`timescale 1ns/10ps
module rtcw_core_asserts
(
    input wire logic MCLK_I,
    input wire logic NRST_I,
    input wire logic [2:0] ADDR_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire rtcw_pkg::rtcw_word_type RDATA_O,
    input wire logic SRC_TICK_I,
    input wire logic ALARM_EVT_I,
    input wire logic SECOND_TICK_O,
    input wire logic MINUTE_TICK_O,
    input wire logic SAMPLE_WIN_O
);
    import rtcw_pkg::*;
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!NRST_I);

    a_rdata_idle: assert property (!$past(RD_I) |-> RDATA_O == 16'h0000)
        else $error("read data not zero outside a read");
    a_time_minutes_seconds_gaps: assert property ($past(RD_I) && $past(ADDR_I) == 3'h0 |->
        RDATA_O[15] == 1'b0 && RDATA_O[7] == 1'b0)
        else $error("time_minutes_seconds spare bits read nonzero");
    a_unmapped_zero: assert property ($past(RD_I) && $past(ADDR_I) >= 3'h6 |->
        RDATA_O == 16'h0000)
        else $error("unmapped read nonzero");
    a_bcd_digits: assert property ($past(RD_I) && $past(ADDR_I) == 3'h0 |->
        RDATA_O[3:0] <= 4'h9 && RDATA_O[6:4] <= 3'h5 &&
        RDATA_O[11:8] <= 4'h9 && RDATA_O[14:12] <= 3'h5)
        else $error("time_minutes_seconds digit out of range");
    a_minute_second: assert property (MINUTE_TICK_O |-> SECOND_TICK_O)
        else $error("minute tick without second tick");
    a_second_cause: assert property (SECOND_TICK_O |-> $past(SRC_TICK_I))
        else $error("second tick without source tick");
    a_second_pulse: assert property (SECOND_TICK_O |=> !SECOND_TICK_O)
        else $error("second tick longer than one cycle");
    a_sample_cause: assert property ($rose(SAMPLE_WIN_O) |-> $past(SRC_TICK_I, 2) ||
        $past(ALARM_EVT_I, 2) || $past(WR_I, 2) || $past(WR_I))
        else $error("sample window opened without cause");
endmodule
bind rtcw_core rtcw_core_asserts u_chk (.MCLK_I(MCLK_I), .NRST_I(NRST_I), .ADDR_I(ADDR_I),
    .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .SRC_TICK_I(SRC_TICK_I),
    .ALARM_EVT_I(ALARM_EVT_I), .SECOND_TICK_O(SECOND_TICK_O),
    .MINUTE_TICK_O(MINUTE_TICK_O), .SAMPLE_WIN_O(SAMPLE_WIN_O));

// File: dv/rtcw_core_tb.sv
// register and power window tests for rtcw_core
// assumes the word map of rtcw_map.svh; source tick made here
`timescale 1ns/10ps
`include "rtcw_map.svh"
module rtcw_core_tb;
    import rtcw_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [2:0] addr = 3'h0;
    rtcw_word_type wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic src_tick = 1'b0;
    logic alarm_evt = 1'b0;
    logic pol = 1'b0;
    rtcw_word_type rdata;
    logic sec_tick;
    logic min_tick;
    logic samp_win;
    logic pwc;
    logic powered;
    int errors = 0;
    int checks_done = 0;
    int tick_gap = 4;
    int tick_cnt = 0;
    int stab_seen = 0;
    int samp_seen = 0;
    int cycles = 0;
    int n;
    rtcw_word_type rv;

    always #20 mclk = ~mclk;
    rtcw_core dut (.MCLK_I(mclk), .NRST_I(nrst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .SRC_TICK_I(src_tick), .ALARM_EVT_I(alarm_evt),
        .SECOND_TICK_O(sec_tick), .MINUTE_TICK_O(min_tick), .SAMPLE_WIN_O(samp_win),
        .PWC_O(pwc));
    rtcw_load_switch u_load (.pwc_i(pwc), .pol_i(pol), .powered_o(powered));

    // ----------------------------------------
    // source tick, window monitor, hang guard
    // ----------------------------------------
    always @(posedge mclk)
    begin
        tick_cnt <= (tick_cnt + 1 >= tick_gap) ? 0 : tick_cnt + 1;
        src_tick <= (tick_cnt + 1 >= tick_gap);
        if (src_tick && samp_win === 1'b1)
            samp_seen <= samp_seen + 1;
        else if (src_tick && powered)
            stab_seen <= stab_seen + 1;
        cycles <= cycles + 1;
        if (cycles == 90000)
        begin
            errors = errors + 1;
            finish_test();
        end
    end

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic check(input string what, input rtcw_word_type seen, input rtcw_word_type exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic reg_write(input logic [2:0] a, input rtcw_word_type d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rd_check(input logic [2:0] a, input rtcw_word_type exp, input string what);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        check(what, rdata, exp);
    endtask

    // counts are in source ticks; stability under /2 may lose one to divider phase
    task automatic run_power(input logic [15:0] win, input logic [15:0] ctl, input int s_lo,
        input int s_hi, input int m);
        reg_write(`RTCW_OFS_ALARM_CFG, 16'h0300);
        reg_write(`RTCW_OFS_ALARM_WINDOW, win);
        reg_write(`RTCW_OFS_POWER_CTRL, ctl);
        pol = ctl[14];
        // output follows a new polarity one edge late; no counting until it has
        repeat (2) @(posedge mclk);
        stab_seen = 0;
        samp_seen = 0;
        @(posedge mclk iff src_tick);
        alarm_evt <= 1'b1;
        @(posedge mclk);
        alarm_evt <= 1'b0;
        #1;
        check("power early", {15'h0, powered}, 16'h0000);
        @(posedge mclk);
        #1;
        check("power on", {15'h0, powered}, 16'h0001);
        for (n = 0; n < 200 && powered; n++)
            @(posedge mclk);
        repeat (2) @(posedge mclk);
        check("stab ok", {15'h0, stab_seen >= s_lo && stab_seen <= s_hi}, 16'h0001);
        check("sample ticks", 16'(samp_seen), 16'(m));
        check("power off", {15'h0, powered}, 16'h0000);
    endtask

    task automatic finish_test();
        $display("checks_done %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial
    begin
        rtcw_word_type masks [4] = '{16'hffff, 16'h1f3f, 16'h073f, 16'h7f7f};
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        reg_write(`RTCW_OFS_TIME_TIME_MINUTES_SECONDS, 16'hd5a9);
        rd_check(`RTCW_OFS_TIME_TIME_MINUTES_SECONDS, 16'h5529, "time time_minutes_seconds");
        reg_write(3'h6, 16'hffff);
        rd_check(3'h6, 16'h0000, "unmapped");
        reg_write(`RTCW_OFS_CLOCK_CFG, 16'h2000);
        reg_write(`RTCW_OFS_ALARM_CFG, 16'h0300);
        repeat (4) reg_write(`RTCW_OFS_ALARM_WINDOW, 16'hffff);
        rd_check(`RTCW_OFS_ALARM_CFG, 16'h0000, "pointer");
        reg_write(`RTCW_OFS_ALARM_CFG, 16'h0300);
        for (int i = 0; i < 4; i++)
            rd_check(`RTCW_OFS_ALARM_WINDOW, masks[i], "alarm word");
        check("sample forever", {15'h0, samp_win}, 16'h0001);
        // locked write must leave weekday/hour as it was
        reg_write(`RTCW_OFS_CLOCK_CFG, 16'h0000);
        reg_write(`RTCW_OFS_ALARM_CFG, 16'h0100);
        reg_write(`RTCW_OFS_ALARM_WINDOW, 16'h0000);
        reg_write(`RTCW_OFS_ALARM_CFG, 16'h0100);
        rd_check(`RTCW_OFS_ALARM_WINDOW, 16'h073f, "locked word");
        reg_write(`RTCW_OFS_CLOCK_CFG, 16'h2000);
        run_power(16'h0203, 16'hc000, 2, 2, 3);
        run_power(16'h0002, 16'hc000, 0, 0, 2);
        run_power(16'h0100, 16'hc000, 1, 1, 0);
        run_power(16'h0202, 16'hf000, 3, 4, 4);
        run_power(16'h0101, 16'h8000, 1, 1, 1);
        reg_write(`RTCW_OFS_CLOCK_CFG, 16'h20fe);
        rd_check(`RTCW_OFS_CLOCK_CFG, 16'h20fe, "negative cal");
        reg_write(`RTCW_OFS_CLOCK_CFG, 16'h2002);
        tick_gap = 1;
        reg_write(`RTCW_OFS_TIME_TIME_MINUTES_SECONDS, 16'h0059);
        n = 0;
        do
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        while (min_tick !== 1'b1 && n < 40000);
        n = 0;
        do
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        while (sec_tick !== 1'b1 && n < 40000);
        check("calibrated second", 16'(n), 16'd32760);
        rd_check(`RTCW_OFS_TIME_TIME_MINUTES_SECONDS, 16'h0101, "time carry");
        finish_test();
    end
endmodule
